// [rtl/spbs_pkg.sv]
package spbs_pkg;

   // ------------------------------------------------------------
   // Register addresses on the special function register port
   // ------------------------------------------------------------
   localparam logic [7:0] SERIAL_CONTROL_STATUS_ADDR  = 8'h98;
   localparam logic [7:0] SERIAL_DATA_BUFFER_ADDR  = 8'h99;
   localparam logic [7:0] BTFD_ADDR  = 8'h9d;
   localparam logic [7:0] BTCON_ADDR = 8'h9e;

   // ------------------------------------------------------------
   // Reset values and implemented bits
   // ------------------------------------------------------------
   localparam logic [7:0] SERIAL_CONTROL_STATUS_RST   = 8'h00;
   localparam logic [7:0] SERIAL_DATA_BUFFER_RST   = 8'h00;
   localparam logic [7:0] BTCON_RST  = 8'h00;
   localparam logic [7:0] BTFD_RST   = 8'h00;
   localparam logic [7:0] BTCON_MASK = 8'h87;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int MODE_HI_POS = 7;
   localparam int MODE_LO_POS = 6;
   localparam int MP_EN_POS   = 5;
   localparam int RX_EN_POS   = 4;
   localparam int TX9_POS     = 3;
   localparam int RX9_POS     = 2;
   localparam int TXDONE_POS  = 1;
   localparam int RXDONE_POS  = 0;
   localparam int BT_EN_POS   = 7;
   localparam int BT_DIV_HI   = 2;

   // ------------------------------------------------------------
   // Timing counts
   // ------------------------------------------------------------
   localparam logic [3:0] M0_LAST_SUB  = 4'hb;  // 12 core cycles a bit
   localparam logic [3:0] M0_RISE_SUB  = 4'h6;  // Shift clock rises here
   localparam logic [3:0] OVS_LAST_SUB = 4'hf;  // 16 ticks a bit
   localparam logic [3:0] OVS_MID_SUB  = 4'h7;  // Middle of a bit
   localparam logic [3:0] BITS8_LAST   = 4'h7;
   localparam logic [3:0] BITS9_LAST   = 4'h8;
   localparam logic [1:0] FIX_LAST     = 2'h3;  // Core clock / 4 tick
   localparam logic [8:0] FRAC_STEP    = 9'h020;
   localparam logic [8:0] FRAC_BASE    = 9'h040;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_SHIFT  = 2'b00,
      MODE_UART8  = 2'b01,
      MODE_UART9F = 2'b10,
      MODE_UART9V = 2'b11
   } spbs_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_DATA  = 2'b11,
      ST_STOP  = 2'b10
   } spbs_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } spbs_sfr_req_t;

   typedef struct packed {
      logic timer_a_ovf;
      logic timer_b_ovf;
      logic timer_b_run;
      logic timer_b_rx_clock_select;
      logic timer_b_tx_clock_select;
      logic legacy_rate_double_bit;
   } spbs_legacy_t;

endpackage

// [rtl/spbs_baud_timer.sv]
`timescale 1ns/10ps

module spbs_baud_timer (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Divider settings
   input  wire logic [2:0] div_sel,
   input  wire logic [7:0] frac_div,
   // Sixteen-times bit rate tick
   output logic            tick16
);
   import spbs_pkg::*;

   typedef struct packed {
      logic [6:0] pre;
      logic [8:0] acc;
      logic       tick;
   } spbs_bt_t;

   spbs_bt_t   s_reg;
   spbs_bt_t   s_next;
   logic [6:0] pre_last;
   logic [8:0] limit;
   logic [8:0] sum;

   // Binary prescaler, then a fractional accumulator; the remainder
   // carries over so the long-run rate is exact, not rounded
   always_comb begin
      pre_last = 7'((8'h01 << div_sel) - 8'h01);
      limit    = {1'b0, frac_div} + FRAC_BASE;
      sum      = s_reg.acc + FRAC_STEP;
      s_next      = s_reg;
      s_next.tick = 1'b0;
      if (s_reg.pre >= pre_last) begin
         s_next.pre = '0;
         if (sum >= limit) begin
            s_next.acc  = sum - limit;
            s_next.tick = 1'b1;
         end else begin
            s_next.acc = sum;
         end
      end else begin
         s_next.pre = s_reg.pre + 7'h01;
      end
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick16 = s_reg.tick;

endmodule

// [rtl/spbs_serial_port.sv]
`timescale 1ns/10ps

module spbs_serial_port (
   // Clock and reset
   input  wire logic                   CLK,
   input  wire logic                   RESETN,
   // Special function register port
   input  wire spbs_pkg::spbs_sfr_req_t SFR_REQ,
   output logic [7:0]                  SFR_RDATA,
   // Legacy baud sources from the general timers
   input  wire spbs_pkg::spbs_legacy_t LEGACY,
   output logic                        TIMER_B_BAUD_MODE,
   // Completion flags to the interrupt controller
   output logic                        TX_DONE_FLAG,
   output logic                        RX_DONE_FLAG,
   // Serial pins
   input  wire logic                   RXD_IN,
   output logic                        RXD_OUT,
   output logic                        RXD_OE_N,
   output logic                        TXD
);
   import spbs_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  serial_control_status;
      logic [7:0]  btcon;
      logic [7:0]  btfd;
      logic [7:0]  rbuf;
      logic [7:0]  rdata;
      logic        sy1;
      logic        sy2;
      logic [1:0]  fix_cnt;
      logic        t1_half;
      spbs_state_t tx_st;
      logic [8:0]  tx_sh;
      logic [3:0]  tx_bit;
      logic [3:0]  tx_sub;
      logic        m0_rx;
      spbs_state_t rx_st;
      logic [8:0]  rx_sh;
      logic [3:0]  rx_bit;
      logic [3:0]  rx_sub;
      logic        txd;
      logic        rxd_out;
      logic        rxd_oe_n;
   } spbs_core_t;

   localparam spbs_core_t CORE_RST = '{
      serial_control_status: SERIAL_CONTROL_STATUS_RST, btcon: BTCON_RST, btfd: BTFD_RST,
      rbuf: SERIAL_DATA_BUFFER_RST, rdata: 8'h00, sy1: 1'b1, sy2: 1'b1,
      fix_cnt: 2'h0, t1_half: 1'b0, tx_st: ST_IDLE,
      tx_sh: 9'h000, tx_bit: 4'h0, tx_sub: 4'h0, m0_rx: 1'b0,
      rx_st: ST_IDLE, rx_sh: 9'h000, rx_bit: 4'h0, rx_sub: 4'h0,
      txd: 1'b1, rxd_out: 1'b1, rxd_oe_n: 1'b1
   };

   spbs_core_t s_reg;
   spbs_core_t s_next;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Baud source of one direction; fixed mode ignores all timers
   function automatic logic pick_tick(
      input spbs_mode_t mode,
      input logic       baud_timer_enable,
      input logic       t2sel,
      input logic       t3tick,
      input logic       t2tick,
      input logic       t1tick,
      input logic       fixtick
   );
      logic t;
      t = t1tick;
      if (mode == MODE_UART9F) begin
         t = fixtick;
      end else if (baud_timer_enable) begin
         t = t3tick;
      end else if (t2sel) begin
         t = t2tick;
      end
      return t;
   endfunction

   // Index of the last data bit for the current mode
   function automatic logic [3:0] last_bit(input spbs_mode_t mode);
      return (mode[1]) ? BITS9_LAST : BITS8_LAST;
   endfunction

   spbs_mode_t mode;
   logic       baud_timer_enable;
   logic       dbl;
   logic       t3_tick;
   logic       t1_tick;
   logic       fix_tick;
   logic       t2_rx_sel;
   logic       t2_tx_sel;
   logic       rx_tick;
   logic       tx_tick;
   logic       wr_serial_control_status;
   logic       wr_serial_data_buffer;
   logic       ti_set;
   logic       ri_set;
   logic       rb8_val;
   logic       tx_en;
   logic       tx_end;
   logic [7:0] rx_data;
   logic       rx_ok;

   // ------------------------------------------------------------
   // Baud sources
   // ------------------------------------------------------------
   spbs_baud_timer u_baud_timer (
      .clk      (CLK),
      .resetn   (RESETN),
      .div_sel  (s_reg.btcon[BT_DIV_HI:0]),
      .frac_div (s_reg.btfd),
      .tick16   (t3_tick)
   );

   // Decoded controls and per-direction ticks
   always_comb begin
      mode     = spbs_mode_t'({s_reg.serial_control_status[MODE_HI_POS], s_reg.serial_control_status[MODE_LO_POS]});
      baud_timer_enable     = s_reg.btcon[BT_EN_POS];
      dbl      = LEGACY.legacy_rate_double_bit;
      // Doubling gives core/32, else core/64, in 16 ticks a bit
      fix_tick = dbl ? s_reg.fix_cnt[0] : (s_reg.fix_cnt == FIX_LAST);
      t1_tick  = LEGACY.timer_a_ovf & (dbl | s_reg.t1_half);
      t2_rx_sel = LEGACY.timer_b_run & LEGACY.timer_b_rx_clock_select;
      t2_tx_sel = LEGACY.timer_b_run & LEGACY.timer_b_tx_clock_select;
      rx_tick  = pick_tick(mode, baud_timer_enable, t2_rx_sel, t3_tick, LEGACY.timer_b_ovf, t1_tick, fix_tick);
      tx_tick  = pick_tick(mode, baud_timer_enable, t2_tx_sel, t3_tick, LEGACY.timer_b_ovf, t1_tick, fix_tick);
      wr_serial_control_status  = SFR_REQ.wr & (SFR_REQ.addr == SERIAL_CONTROL_STATUS_ADDR);
      wr_serial_data_buffer  = SFR_REQ.wr & (SFR_REQ.addr == SERIAL_DATA_BUFFER_ADDR);
      // Shift mode clocks every core cycle, 12 cycles a bit
      tx_en    = (mode == MODE_SHIFT) ? 1'b1 : tx_tick;
      tx_end   = (mode == MODE_SHIFT) ? (s_reg.tx_sub == M0_LAST_SUB)
                                      : (s_reg.tx_sub == OVS_LAST_SUB);
   end

   // Timer B loses only its overflow flag in baud mode; its external
   // flag path is untouched and still interrupts
   assign TIMER_B_BAUD_MODE = LEGACY.timer_b_run
                            & (LEGACY.timer_b_rx_clock_select
                             | LEGACY.timer_b_tx_clock_select);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_next  = s_reg;
      ti_set  = 1'b0;
      ri_set  = 1'b0;
      rb8_val = s_reg.serial_control_status[RX9_POS];
      rx_data = 8'h00;
      rx_ok   = 1'b0;

      // Receive pin synchroniser and legacy prescalers
      s_next.sy1     = RXD_IN;
      s_next.sy2     = s_reg.sy1;
      s_next.fix_cnt = s_reg.fix_cnt + 2'h1;
      if (LEGACY.timer_a_ovf) begin
         s_next.t1_half = ~s_reg.t1_half;
      end

      // Transmit engine; in shift mode it also runs shift receive
      case (s_reg.tx_st)
         ST_IDLE: begin
            s_next.tx_sub = 4'h0;
            s_next.tx_bit = 4'h0;
            if (wr_serial_data_buffer) begin
               s_next.tx_sh = {s_reg.serial_control_status[TX9_POS], SFR_REQ.wdata};
               s_next.m0_rx = 1'b0;
               // Shift mode skips start bit, data goes at once
               s_next.tx_st = (mode == MODE_SHIFT) ? ST_DATA : ST_START;
            end else if (mode == MODE_SHIFT && s_reg.serial_control_status[RX_EN_POS]
                         && !s_reg.serial_control_status[RXDONE_POS]) begin
               s_next.m0_rx = 1'b1;
               s_next.tx_st = ST_DATA;
            end
         end
         ST_START: begin
            if (tx_en) begin
               s_next.tx_sub = s_reg.tx_sub + 4'h1;
               if (tx_end) begin
                  s_next.tx_st = ST_DATA;
               end
            end
         end
         ST_DATA: begin
            if (tx_en) begin
               s_next.tx_sub = s_reg.tx_sub + 4'h1;
               // Shift receive samples on the rising shift clock
               if (mode == MODE_SHIFT && s_reg.m0_rx && s_reg.tx_sub == M0_RISE_SUB) begin
                  s_next.rx_sh = {1'b0, s_reg.sy2, s_reg.rx_sh[7:1]};
               end
               if (tx_end) begin
                  s_next.tx_sub = 4'h0;
                  s_next.tx_sh  = {1'b0, s_reg.tx_sh[8:1]};
                  s_next.tx_bit = s_reg.tx_bit + 4'h1;
                  if (mode == MODE_SHIFT) begin
                     if (s_reg.tx_bit == BITS8_LAST) begin
                        s_next.tx_st = ST_IDLE;
                        // Eight bits moved, flag at end of the eighth
                        if (s_reg.m0_rx) begin
                           ri_set  = 1'b1;
                           rx_data = s_next.rx_sh[7:0];
                           rx_ok   = 1'b1;
                        end else begin
                           ti_set = 1'b1;
                        end
                     end
                  end else if (s_reg.tx_bit == last_bit(mode)) begin
                     s_next.tx_st = ST_STOP;
                     ti_set       = 1'b1;
                  end
               end
            end
         end
         ST_STOP: begin
            if (tx_en) begin
               s_next.tx_sub = s_reg.tx_sub + 4'h1;
               if (tx_end) begin
                  s_next.tx_st = ST_IDLE;
               end
            end
         end
         default: s_next.tx_st = ST_IDLE;
      endcase

      // Shift receive stops as soon as enable drops
      if (s_reg.m0_rx && !s_reg.serial_control_status[RX_EN_POS]) begin
         s_next.tx_st = ST_IDLE;
         s_next.m0_rx = 1'b0;
      end

      // Asynchronous receive engine, 16 ticks a bit
      case (s_reg.rx_st)
         ST_IDLE: begin
            s_next.rx_sub = 4'h0;
            s_next.rx_bit = 4'h0;
            if (rx_tick && !s_reg.sy2 && mode != MODE_SHIFT && s_reg.serial_control_status[RX_EN_POS]) begin
               s_next.rx_st = ST_START;
            end
         end
         ST_START: begin
            if (rx_tick) begin
               s_next.rx_sub = s_reg.rx_sub + 4'h1;
               if (s_reg.rx_sub == OVS_MID_SUB) begin
                  // A glitch shorter than half a bit is no start
                  s_next.rx_sub = 4'h0;
                  s_next.rx_st  = s_reg.sy2 ? ST_IDLE : ST_DATA;
               end
            end
         end
         ST_DATA: begin
            if (rx_tick) begin
               s_next.rx_sub = s_reg.rx_sub + 4'h1;
               if (s_reg.rx_sub == OVS_LAST_SUB) begin
                  s_next.rx_sh  = {s_reg.sy2, s_reg.rx_sh[8:1]};
                  s_next.rx_bit = s_reg.rx_bit + 4'h1;
                  if (s_reg.rx_bit == last_bit(mode)) begin
                     s_next.rx_st = ST_STOP;
                  end
               end
            end
         end
         ST_STOP: begin
            if (rx_tick) begin
               s_next.rx_sub = s_reg.rx_sub + 4'h1;
               if (s_reg.rx_sub == OVS_LAST_SUB) begin
                  // Middle of the stop bit: frame complete
                  s_next.rx_st = ST_IDLE;
                  if (mode == MODE_UART8) begin
                     rx_data = s_reg.rx_sh[8:1];
                     rb8_val = s_reg.sy2;
                     rx_ok   = !s_reg.serial_control_status[MP_EN_POS] || s_reg.sy2;
                  end else begin
                     rx_data = s_reg.rx_sh[7:0];
                     rb8_val = s_reg.rx_sh[8];
                     rx_ok   = !s_reg.serial_control_status[MP_EN_POS] || s_reg.rx_sh[8];
                  end
                  ri_set = rx_ok;
               end
            end
         end
         default: s_next.rx_st = ST_IDLE;
      endcase

      // Clearing enable drops a frame in progress
      if (!s_reg.serial_control_status[RX_EN_POS] || mode == MODE_SHIFT) begin
         s_next.rx_st = ST_IDLE;
      end

      // Unread byte is simply replaced
      if (rx_ok) begin
         s_next.rbuf = rx_data;
      end

      // Register writes; hardware set wins over a clearing write
      if (wr_serial_control_status) begin
         s_next.serial_control_status = SFR_REQ.wdata;
      end
      if (ti_set) begin
         s_next.serial_control_status[TXDONE_POS] = 1'b1;
      end
      if (ri_set) begin
         s_next.serial_control_status[RXDONE_POS] = 1'b1;
         if (mode != MODE_SHIFT) begin
            s_next.serial_control_status[RX9_POS] = rb8_val;
         end
      end
      if (SFR_REQ.wr && SFR_REQ.addr == BTCON_ADDR) begin
         s_next.btcon = SFR_REQ.wdata & BTCON_MASK;
      end
      if (SFR_REQ.wr && SFR_REQ.addr == BTFD_ADDR) begin
         s_next.btfd = SFR_REQ.wdata;
      end

      // Read data held until the next read
      if (SFR_REQ.rd) begin
         case (SFR_REQ.addr)
            SERIAL_CONTROL_STATUS_ADDR:  s_next.rdata = s_reg.serial_control_status;
            SERIAL_DATA_BUFFER_ADDR:  s_next.rdata = s_reg.rbuf;
            BTCON_ADDR: s_next.rdata = s_reg.btcon;
            BTFD_ADDR:  s_next.rdata = s_reg.btfd;
            default:    s_next.rdata = 8'h00;
         endcase
      end

      // Pin drive from the next engine state, so pins are registered
      s_next.txd      = 1'b1;
      s_next.rxd_out  = 1'b1;
      s_next.rxd_oe_n = 1'b1;
      if (mode == MODE_SHIFT) begin
         if (s_next.tx_st == ST_DATA) begin
            // Clock low first half of each bit, high second half
            s_next.txd = (s_next.tx_sub >= M0_RISE_SUB);
            if (!s_next.m0_rx) begin
               s_next.rxd_out  = s_next.tx_sh[0];
               s_next.rxd_oe_n = 1'b0;
            end
         end
      end else begin
         case (s_next.tx_st)
            ST_START: s_next.txd = 1'b0;
            ST_DATA:  s_next.txd = s_next.tx_sh[0];
            default:  s_next.txd = 1'b1;
         endcase
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         s_reg <= CORE_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign SFR_RDATA    = s_reg.rdata;
   assign TX_DONE_FLAG = s_reg.serial_control_status[TXDONE_POS];
   assign RX_DONE_FLAG = s_reg.serial_control_status[RXDONE_POS];
   assign TXD          = s_reg.txd;
   assign RXD_OUT      = s_reg.rxd_out;
   assign RXD_OE_N     = s_reg.rxd_oe_n;

endmodule

// [verif/spbs_serial_port_properties.sv]
`timescale 1ns/10ps
module spbs_serial_port_props (
   // Clock, reset, register port and pins
   input wire logic                    CLK,
   input wire logic                    RESETN,
   input wire spbs_pkg::spbs_sfr_req_t SFR_REQ,
   input wire logic [7:0]              SFR_RDATA,
   input wire spbs_pkg::spbs_legacy_t  LEGACY,
   input wire logic                    TIMER_B_BAUD_MODE,
   input wire logic                    TX_DONE_FLAG,
   input wire logic                    RX_DONE_FLAG,
   input wire logic                    RXD_IN,
   input wire logic                    RXD_OUT,
   input wire logic                    RXD_OE_N,
   input wire logic                    TXD
);
   import spbs_pkg::*;
   logic [2:0] ctl_reg;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   // Control writes decoded; mode and enable mirrored, since they are not on the pins
   wire serial_control_status_wr = SFR_REQ.wr && SFR_REQ.addr == SERIAL_CONTROL_STATUS_ADDR;
   wire clr_tx  = serial_control_status_wr && !SFR_REQ.wdata[1];
   wire clr_rx  = serial_control_status_wr && !SFR_REQ.wdata[0];
   wire shift_m = ctl_reg[2:1] == 2'h0;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) ctl_reg <= 3'h0;
      else if (serial_control_status_wr) ctl_reg <= {SFR_REQ.wdata[7:6], SFR_REQ.wdata[4]};
   end
   baud_mode_a: assert property (TIMER_B_BAUD_MODE == (LEGACY.timer_b_run &&
      (LEGACY.timer_b_rx_clock_select || LEGACY.timer_b_tx_clock_select))) else $error("timer b mode");
   tx_flag_hold_a: assert property ($fell(TX_DONE_FLAG) |-> $past(clr_tx))
      else $error("tx flag lost");
   rx_flag_hold_a: assert property ($fell(RX_DONE_FLAG) |-> $past(clr_rx))
      else $error("rx flag lost");
   rx_flag_en_a: assert property ($rose(RX_DONE_FLAG) |-> ctl_reg[0])
      else $error("rx while disabled");
   tx_flag_stop_a: assert property ($rose(TX_DONE_FLAG) && !shift_m |-> ##2 TXD [*8])
      else $error("no stop bit");
   shift_drive_a: assert property (!RXD_OE_N |-> shift_m)
      else $error("data pin driven");
   shift_start_a: assert property (SFR_REQ.wr && SFR_REQ.addr == SERIAL_DATA_BUFFER_ADDR && shift_m && !ctl_reg[0]
      && RXD_OE_N && TXD |-> ##2 !TXD && !RXD_OE_N) else $error("shift not started");
   shift_clock_a: assert property ($fell(TXD) && shift_m |-> !TXD [*6] ##1 TXD)
      else $error("shift clock shape");
endmodule

// [verif/spbs_remote_model.sv]
`timescale 1ns/10ps
module spbs_remote_model #(parameter int BITC = 64) (
   // Clock and line pins
   input  wire logic clk,
   input  wire logic txd,
   output logic      rxd
);
   logic [8:0] got = '0;
   // Line idles high between frames
   initial rxd = 1'b1;
   // Start low, nine bits LSB first, high stop
   task automatic send(input logic [8:0] d);
      logic [10:0] fr;
      fr = {1'b1, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd <= fr[i];
         repeat (BITC) @(negedge clk);
      end
   endtask
   // Samples the nine bits after the start bit of a device frame, each at its middle
   always begin
      @(negedge txd);
      repeat (BITC / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         repeat (BITC) @(posedge clk);
         got[i] = txd;
      end
   end
endmodule

// [verif/serial_port_baud_select_bench.sv]
`timescale 1ns/10ps
module serial_port_baud_select_bench;
   import spbs_pkg::*;
   logic          CLK = 1'b0, RESETN = 1'b0;
   spbs_sfr_req_t SFR_REQ = '0;
   spbs_legacy_t  LEGACY = 6'h0c;
   logic [7:0]    SFR_RDATA, q, sh;
   logic          TIMER_B_BAUD_MODE, TX_DONE_FLAG, RX_DONE_FLAG, RXD_IN, RXD_OUT, RXD_OE_N, TXD;
   int            fail_count = 0, checks_done = 0;
   logic [23:0]   rows [7] = '{24'h98d0d0, 24'h985050, 24'h9eff87, 24'h9d1212, 24'h905500, 24'h9e0000,
                               24'h980000};
   // Fixed rate mode gives 64 core cycles a bit at the far end
   spbs_serial_port uut (.CLK, .RESETN, .SFR_REQ, .SFR_RDATA, .LEGACY, .TIMER_B_BAUD_MODE,
      .TX_DONE_FLAG, .RX_DONE_FLAG, .RXD_IN, .RXD_OUT, .RXD_OE_N, .TXD);
   spbs_remote_model #(.BITC(64)) rm (.clk(CLK), .txd(TXD), .rxd(RXD_IN));
   // Core clock
   initial forever #10 CLK = ~CLK;
   // One register cycle; a read leaves its data in q
   task automatic acc(input logic [7:0] a, d, input logic w);
      @(negedge CLK);
      SFR_REQ <= '{a, d, w, !w};
      @(negedge CLK);
      SFR_REQ <= '0;
      q = SFR_RDATA;
   endtask
   task automatic chk(input logic [8:0] g, e, input string m);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %0t %s got %h want %h", $time, m, g, e);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (8) @(negedge CLK);
      RESETN = 1'b1;
      acc(SERIAL_CONTROL_STATUS_ADDR, 8'h00, 1'b0);
      chk(q, 8'h00, "reset");
      foreach (rows[i]) begin
         acc(rows[i][23:16], rows[i][15:8], 1'b1);
         acc(rows[i][23:16], 8'h00, 1'b0);
         chk(q, rows[i][7:0], "register");
      end
      acc(SERIAL_CONTROL_STATUS_ADDR, 8'hb8, 1'b1);
      fork
         rm.send(9'h0c3);
         acc(SERIAL_DATA_BUFFER_ADDR, 8'ha5, 1'b1);
      join
      chk(rm.got, 9'h1a5, "frame");
      chk(RX_DONE_FLAG, 1'b0, "filter");
      rm.send(9'h13c);
      rm.send(9'h15a);
      acc(SERIAL_CONTROL_STATUS_ADDR, 8'h00, 1'b0);
      chk(q, 8'hbf, "status");
      acc(SERIAL_DATA_BUFFER_ADDR, 8'h00, 1'b0);
      chk(q, 8'h5a, "overrun");
      // 8-bit mode on the fractional timer: 4 cycles a tick, 64 a bit
      acc(BTCON_ADDR, 8'h80, 1'b1);
      acc(BTFD_ADDR, 8'h40, 1'b1);
      acc(SERIAL_CONTROL_STATUS_ADDR, 8'h70, 1'b1);
      rm.send(9'h0aa);
      chk(RX_DONE_FLAG, 1'b0, "bad stop");
      rm.send(9'h155);
      acc(SERIAL_CONTROL_STATUS_ADDR, 8'h00, 1'b0);
      chk(q, 8'h75, "stop bit");
      acc(SERIAL_DATA_BUFFER_ADDR, 8'h00, 1'b0);
      chk(q, 8'h55, "8-bit byte");
      acc(SERIAL_CONTROL_STATUS_ADDR, 8'ha8, 1'b1);
      rm.send(9'h1ff);
      chk(RX_DONE_FLAG, 1'b0, "rx off");
      LEGACY = '0;
      acc(SERIAL_CONTROL_STATUS_ADDR, 8'h00, 1'b1); // Shift mode with multiprocessor bit clear
      acc(SERIAL_DATA_BUFFER_ADDR, 8'h96, 1'b1);
      for (int i = 0; i < 8; i++) begin
         @(posedge TXD);
         sh[i] = RXD_OUT;
      end
      repeat (20) @(negedge CLK);
      chk(sh, 8'h96, "shift out");
      chk(TX_DONE_FLAG, 1'b1, "shift tx");
      acc(SERIAL_CONTROL_STATUS_ADDR, 8'h10, 1'b1);
      repeat (120) @(negedge CLK);
      acc(SERIAL_DATA_BUFFER_ADDR, 8'h00, 1'b0);
      chk({RX_DONE_FLAG, q}, 9'h1ff, "shift in");
      // Second reset in mid-run: everything back to idle
      RESETN = 1'b0;
      repeat (2) @(negedge CLK);
      RESETN = 1'b1;
      acc(SERIAL_CONTROL_STATUS_ADDR, 8'h00, 1'b0);
      chk(q, 8'h00, "re-reset");
      chk(TXD, 1'b1, "idle line");
      end_of_test();
   end
   // Hang guard, well past the few thousand cycles needed
   initial begin
      repeat (20000) @(posedge CLK);
      fail_count++;
      end_of_test();
   end
endmodule
bind spbs_serial_port spbs_serial_port_props chk_i (.CLK, .RESETN, .SFR_REQ, .SFR_RDATA, .LEGACY,
   .TIMER_B_BAUD_MODE, .TX_DONE_FLAG, .RX_DONE_FLAG, .RXD_IN, .RXD_OUT, .RXD_OE_N, .TXD);
